// ===== src/spi_nvm_regs.svh
// Op-codes, status bit positions, reset values and sizes of the serial memory core
`ifndef SPI_NVM_REGS_SVH
`define SPI_NVM_REGS_SVH

// Command op-codes, MSB first on the serial input
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_READ 8'h03
`define OP_MEM_WRITE 8'h02
`define OP_DEVICE_ID 8'h9F
`define OP_FAST_READ 8'h0B
`define OP_SLEEP 8'hB9

// Field lengths in serial bits
`define OP_BITS 8
`define ADDR_BITS 24
`define DATA_BITS 8
`define LAST_OP_BIT 5'h07
`define LAST_ADDR_BIT 5'h17
`define LAST_DATA_BIT 5'h07

// Memory geometry: 18 address bits survive, top six are dropped
`define MEM_AW 18
`define MEM_WORDS 262144

// Status register layout
`define ST_LOCK_BIT 7
`define ST_GUARD_HI_BIT 3
`define ST_GUARD_LO_BIT 2
`define ST_WEL_BIT 1
`define ST_NV_MSB 7
`define ST_NV_LSB 2
`define ST_NV_RESET 6'h00
`define WEL_RESET 1'b0

// Write buffer between serial front end and array
`define WBUF_DEPTH 16
`define WBUF_WIDTH 26

`endif

// ===== src/spi_nvm_pkg.sv
// Types shared by the serial memory command core
package spi_nvm_pkg;
	`include "spi_nvm_regs.svh"

	// Phase of the current chip-select frame
	typedef enum logic [2:0] {
		PH_OPCODE,
		PH_ADDR,
		PH_STAT_RD,
		PH_STAT_WR,
		PH_MEM_RD,
		PH_MEM_WR,
		PH_IGNORE
	} phase_t;

	// Complete register state of the command core
	typedef struct packed {
		logic [1:0] cs_sync;
		logic [1:0] sck_sync;
		logic [1:0] si_sync;
		logic [1:0] wp_sync;
		logic sck_last;
		phase_t phase;
		logic is_write;
		logic [7:0] in_sh;
		logic [4:0] bit_cnt;
		logic [`MEM_AW-1:0] addr;
		logic write_enable_latch;
		logic [5:0] nv;
		logic write_seen;
		logic [7:0] out_sh;
		logic [2:0] out_cnt;
		logic so;
		logic so_oe_n;
		logic fetch_req;
	} core_state_t;
endpackage

// ===== src/sync_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} fifo_ptr_t;

	fifo_ptr_t r;
	fifo_ptr_t next_r;
	logic [WIDTH-1:0] store [DEPTH];
	logic full;
	logic empty;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign full = (r.wr_ptr[AW] != r.rd_ptr[AW]) && (r.wr_ptr[AW-1:0] == r.rd_ptr[AW-1:0]);
	assign empty = (r.wr_ptr == r.rd_ptr);
	assign o_in_ready = ~full;
	assign o_out_valid = ~empty;
	assign o_out_data = store[r.rd_ptr[AW-1:0]];
	assign push = i_in_valid & ~full;
	assign pop = i_out_ready & ~empty;

	// Pointer advance
	always_comb
	begin
		next_r = r;
		if (push)
			next_r.wr_ptr = r.wr_ptr + 1'b1;
		if (pop)
			next_r.rd_ptr = r.rd_ptr + 1'b1;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			r <= '0;
		else
			r <= next_r;
	end

	// Storage needs no reset; empty hides stale words
	always_ff @(posedge i_mclk)
	begin
		if (push)
			store[r.wr_ptr[AW-1:0]] <= i_in_data;
	end
endmodule

// ===== src/serial_nvm_command_core.sv
// Command interpreter of a serial nonvolatile memory acting as SPI slave
`timescale 1ns/1ps
// Summary of operation
// - Six commands, each picked by an 8-bit op-code first after chip select falls.
// - Latch-set op-code 06h sets the write enable latch.
// - Latch-clear op-code 04h clears the write enable latch.
// - After op-code 05h the status byte shifts out, changing on falling edges.
// - Status read repeats the status byte while clocking continues.
// - Op-code 01h plus one byte stores the nonvolatile status bits.
// - Status write ignores bits 1 and 0; bit 0 always reads zero.
// - Op-code 03h plus 24-bit address reads; top six address bits ignored.
// - Read data goes out eight clocks per byte; serial input disregarded.
// - Read address advances per byte and wraps from top to zero.
// - Op-code 02h, 24-bit address with top six ignored, then data bytes.
// - Each write byte is committed once its eight bits arrive.
// - Further write bytes go to successive addresses, wrapping to zero.
// - Chip select rising during the op-code executes nothing.
// - Status and memory writes are suppressed while the latch is clear.
// - Latch clears at reset, on latch-clear, and frame end after writes.
// - Status bits 6 to 4 are spare nonvolatile bits, writable and readable.
// - Status bits 3 and 2 pick the write-guarded array region.
// - Status bit 7 with write-protect pin low blocks status writes.
// - Input sampled on rising clock edges, output driven on falling edges.
// - Both SPI mode 0 and mode 3 are accepted.
// - Chip select high ignores inputs and floats serial output.
module serial_nvm_command_core
	import spi_nvm_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Serial link pins
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_si,
	input wire logic i_wp_n,
	output logic o_so,
	output logic o_so_oe_n
);
	core_state_t r;
	core_state_t next_r;

	// Array and its read port
	logic [7:0] mem [`MEM_WORDS];
	logic [7:0] rd_data;

	// Decoded link events and helpers
	logic cs_hi;
	logic sck_rise;
	logic sck_fall;
	logic [7:0] shin;
	logic [7:0] stat_byte;
	logic stat_lock;

	// Write buffer signals
	logic wbuf_push;
	logic wbuf_ready;
	logic wbuf_valid;
	logic [`WBUF_WIDTH-1:0] wbuf_data;
	logic wbuf_pop;

	// Region guarded by the two block guard bits
	function automatic logic guarded(input logic [1:0] guard, input logic [`MEM_AW-1:0] a);
		logic hit;
		hit = 1'b0;
		unique case (guard)
			2'b00: hit = 1'b0;
			2'b01: hit = (a[`MEM_AW-1:`MEM_AW-2] == 2'b11);
			2'b10: hit = a[`MEM_AW-1];
			2'b11: hit = 1'b1;
		endcase
		return hit;
	endfunction

	// Status image: spare, guard and lock bits, latch, fixed zero
	assign stat_byte = {r.nv, r.write_enable_latch, 1'b0};
	assign stat_lock = r.nv[`ST_LOCK_BIT-`ST_NV_LSB] & ~r.wp_sync[1];
	assign cs_hi = r.cs_sync[1];
	assign sck_rise = r.sck_sync[1] & ~r.sck_last;
	assign sck_fall = ~r.sck_sync[1] & r.sck_last;
	assign shin = {r.in_sh[6:0], r.si_sync[1]};

	// Next-state logic of the whole command core
	always_comb
	begin
		next_r = r;
		wbuf_push = 1'b0;
		next_r.cs_sync = {r.cs_sync[0], i_cs_n};
		next_r.sck_sync = {r.sck_sync[0], i_sck};
		next_r.si_sync = {r.si_sync[0], i_si};
		next_r.wp_sync = {r.wp_sync[0], i_wp_n};
		next_r.sck_last = r.sck_sync[1];
		next_r.fetch_req = 1'b0;
		if (cs_hi)
		begin
			// Deselected: drop any partial field and float the output
			if (r.write_seen)
				next_r.write_enable_latch = 1'b0;
			next_r.phase = PH_OPCODE;
			next_r.bit_cnt = 5'h00;
			next_r.write_seen = 1'b0;
			next_r.out_cnt = 3'h0;
			next_r.so = 1'b0;
			next_r.so_oe_n = 1'b1;
		end
		else if (sck_rise)
		begin
			// Mode 3 opens on a falling edge, which no input phase uses
			next_r.in_sh = shin;
			next_r.bit_cnt = r.bit_cnt + 5'h01;
			unique case (r.phase)
				PH_OPCODE:
				begin
					if (r.bit_cnt == `LAST_OP_BIT)
					begin
						next_r.bit_cnt = 5'h00;
						next_r.phase = PH_IGNORE;
						unique case (shin)
							`OP_LATCH_SET: next_r.write_enable_latch = 1'b1;
							`OP_LATCH_CLEAR: next_r.write_enable_latch = 1'b0;
							`OP_STATUS_READ: next_r.phase = PH_STAT_RD;
							`OP_STATUS_WRITE:
							begin
								next_r.phase = PH_STAT_WR;
								next_r.write_seen = 1'b1;
							end
							`OP_MEM_READ:
							begin
								next_r.phase = PH_ADDR;
								next_r.is_write = 1'b0;
							end
							`OP_MEM_WRITE:
							begin
								next_r.phase = PH_ADDR;
								next_r.is_write = 1'b1;
								next_r.write_seen = 1'b1;
							end
							`OP_DEVICE_ID, `OP_FAST_READ, `OP_SLEEP: next_r.phase = PH_IGNORE;
							default: next_r.phase = PH_IGNORE;
						endcase
					end
				end
				PH_ADDR:
				begin
					// Upper six address bits fall off the top of the shifter
					next_r.addr = {r.addr[`MEM_AW-2:0], r.si_sync[1]};
					if (r.bit_cnt == `LAST_ADDR_BIT)
					begin
						next_r.bit_cnt = 5'h00;
						next_r.phase = r.is_write ? PH_MEM_WR : PH_MEM_RD;
						next_r.fetch_req = ~r.is_write;
					end
				end
				PH_STAT_WR:
				begin
					if (r.bit_cnt == `LAST_DATA_BIT)
					begin
						next_r.bit_cnt = 5'h00;
						next_r.phase = PH_IGNORE;
						if (r.write_enable_latch && !stat_lock)
							next_r.nv = shin[`ST_NV_MSB:`ST_NV_LSB];
					end
				end
				PH_MEM_WR:
				begin
					if (r.bit_cnt == `LAST_DATA_BIT)
					begin
						// Address advances even for a suppressed byte
						next_r.bit_cnt = 5'h00;
						next_r.addr = r.addr + 1'b1;
						wbuf_push = r.write_enable_latch && wbuf_ready &&
							!guarded(r.nv[1:0], r.addr);
					end
				end
				default:
				begin
					// Reads and finished commands disregard serial input
					next_r.bit_cnt = 5'h00;
				end
			endcase
		end
		else if (sck_fall && (r.phase == PH_STAT_RD || r.phase == PH_MEM_RD))
		begin
			next_r.so_oe_n = 1'b0;
			next_r.out_cnt = r.out_cnt + 3'h1;
			if (r.out_cnt == 3'h0)
			begin
				// Byte boundary: load next byte; memory reads also prefetch the one after
				if (r.phase == PH_STAT_RD)
				begin
					next_r.so = stat_byte[7];
					next_r.out_sh = {stat_byte[6:0], 1'b0};
				end
				else
				begin
					next_r.so = rd_data[7];
					next_r.out_sh = {rd_data[6:0], 1'b0};
					next_r.addr = r.addr + 1'b1;
					next_r.fetch_req = 1'b1;
				end
			end
			else
			begin
				next_r.so = r.out_sh[7];
				next_r.out_sh = {r.out_sh[6:0], 1'b0};
			end
		end
	end

	// State register; nonvolatile bits restart at their reset image
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			r <= '0;
			r.phase <= PH_OPCODE;
			r.cs_sync <= 2'h3;
			r.wp_sync <= 2'h3;
			r.nv <= `ST_NV_RESET;
			r.write_enable_latch <= `WEL_RESET;
			r.so_oe_n <= 1'b1;
		end
		else
			r <= next_r;
	end

	// Reads win the single array port; buffered writes wait a cycle
	assign wbuf_pop = ~r.fetch_req;

	always_ff @(posedge i_mclk)
	begin
		if (r.fetch_req)
			rd_data <= mem[r.addr];
		else if (wbuf_valid)
			mem[wbuf_data[`WBUF_WIDTH-1:8]] <= wbuf_data[7:0];
	end

	// Write bytes queue here so a read fetch never loses one
	sync_fifo #(
		.WIDTH(`WBUF_WIDTH),
		.DEPTH(`WBUF_DEPTH)
	) u_wbuf (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_in_valid(wbuf_push),
		.i_in_data({r.addr, shin}),
		.o_in_ready(wbuf_ready),
		.o_out_valid(wbuf_valid),
		.o_out_data(wbuf_data),
		.i_out_ready(wbuf_pop)
	);

	assign o_so = r.so;
	assign o_so_oe_n = r.so_oe_n;

	// Checks on the command core
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	a_float_deselected: assert property (cs_hi |=> r.so_oe_n)
		else $error("serial output driven while deselected");
	a_short_op_noop: assert property (cs_hi |=> r.phase == PH_OPCODE && r.bit_cnt == 5'h00)
		else $error("frame state kept past chip select rise");
	a_latch_set_op: assert property (!cs_hi && sck_rise && r.phase == PH_OPCODE &&
		r.bit_cnt == `LAST_OP_BIT && shin == `OP_LATCH_SET |=> r.write_enable_latch)
		else $error("latch-set op-code did not set latch");
	a_latch_clear_op: assert property (!cs_hi && sck_rise && r.phase == PH_OPCODE &&
		r.bit_cnt == `LAST_OP_BIT && shin == `OP_LATCH_CLEAR |=> !r.write_enable_latch)
		else $error("latch-clear op-code did not clear latch");
	a_wel_frame_end: assert property (cs_hi && r.write_seen |=> !r.write_enable_latch ##1 !r.write_enable_latch)
		else $error("latch survived end of write frame");
	a_nv_needs_wel: assert property (r.nv != $past(r.nv) |-> $past(r.write_enable_latch) && !$past(stat_lock))
		else $error("status bits changed without permission");
	a_push_needs_wel: assert property (wbuf_push |-> r.write_enable_latch && r.phase == PH_MEM_WR)
		else $error("memory write queued with latch clear");
	a_write_addr_step: assert property (wbuf_push |=> r.addr == $past(r.addr) + 1'b1)
		else $error("write address did not advance");
	a_stat_msb_out: assert property (!cs_hi && sck_fall && r.phase == PH_STAT_RD && r.out_cnt == 3'h0
		|=> r.so == $past(stat_byte[7]) && !r.so_oe_n)
		else $error("status MSB not driven");
	a_read_fetch: assert property (!cs_hi && sck_fall && r.phase == PH_MEM_RD && r.out_cnt == 3'h0
		|=> r.fetch_req ##2 rd_data === mem[$past(r.addr, 2)])
		else $error("read did not fetch next address");
	a_read_ignores_si: assert property (r.phase == PH_MEM_RD && !cs_hi |=> $stable(r.nv))
		else $error("status changed during memory read");

	c_status_read: cover property (sck_fall && r.phase == PH_STAT_RD && r.out_cnt == 3'h7);
	c_mem_write: cover property (wbuf_push);
	c_read_wrap: cover property (r.phase == PH_MEM_RD && r.fetch_req && r.addr == '0);
	c_status_write: cover property (r.nv != $past(r.nv));
endmodule

// ===== dv/spi_master_model.sv
// Behavioural SPI master that drives the serial memory pins
`timescale 1ns/1ps
module spi_master_model (
	// Clock
	input wire logic i_mclk,
	// Serial pins from the device
	input wire logic i_so,
	input wire logic i_so_oe_n,
	// Serial pins to the device
	output logic o_cs_n,
	output logic o_sck,
	output logic o_si,
	output logic o_wp_n
);
	logic mode3;

	// Deselected, clock idle low at time zero
	initial
	begin
		mode3 = 1'b0;
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
		o_wp_n = 1'b1;
	end

	// Whole mclk cycles, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	// Protect pin only moves while deselected, so it is steady across a frame
	task automatic start(input logic m3, input logic wp_n);
		mode3 = m3;
		o_sck = m3;
		o_wp_n = wp_n;
		tick(4);
		o_cs_n = 1'b0;
		tick(4);
	endtask

	// MSB first; bench sends defined op-codes only and full 24-bit addresses
	task automatic shift(input logic [31:0] v, input int n, output logic [31:0] r);
		r = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			if (mode3)
				o_sck = 1'b0;
			o_si = v[i];
			tick(16);
			o_sck = 1'b1;
			r = {r[30:0], i_so_oe_n ? ~i_so : i_so}; // Floating SO reads as the inverse, never stale
			tick(16);
			if (!mode3)
				o_sck = 1'b0;
		end
	endtask

	// Released SI shows the inverse of its last value, never a stale one
	task automatic stop();
		tick(16);
		o_cs_n = 1'b1;
		o_si = ~o_si;
		tick(8);
	endtask
endmodule

// ===== dv/tb_serial_nvm_command_core.sv
// Self-checking bench of the serial memory command core
`timescale 1ns/1ps
module tb_serial_nvm_command_core;
	typedef struct {
		logic [7:0] pre;
		logic [7:0] op;
		logic [7:0] arg;
		logic wp_n;
		logic [7:0] exp;
	} row_t;

	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic md = 1'b0;
	logic [31:0] r;
	wire cs_n, sck, si, wp_n, so, so_oe_n;
	int n_mismatch = 0;
	int checked = 0;
	// Pre-command, command, payload, protect pin, expected status
	row_t rows [8] = '{
		'{8'h00, 8'h06, 8'h00, 1'b1, 8'h02},
		'{8'h06, 8'h04, 8'h00, 1'b1, 8'h00},
		'{8'h06, 8'h01, 8'hFF, 1'b1, 8'hFC},
		'{8'h00, 8'h01, 8'h00, 1'b1, 8'hFC},
		'{8'h06, 8'h01, 8'h00, 1'b0, 8'hFC},
		'{8'h06, 8'h01, 8'h70, 1'b1, 8'h70},
		'{8'h06, 8'h9F, 8'h00, 1'b1, 8'h72},
		'{8'h06, 8'h01, 8'h00, 1'b1, 8'h00}
	};

	// Clock and reset
	always #2.5 i_mclk = ~i_mclk;

	serial_nvm_command_core u_serial_nvm_command_core (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck),
		.i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(so_oe_n)
	);

	spi_master_model u_spi_master_model (
		.i_mclk(i_mclk), .i_so(so), .i_so_oe_n(so_oe_n),
		.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_wp_n(wp_n)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Op-code plus optional payload of nb bits
	task automatic cmd(input logic [7:0] op, input logic [7:0] pay, input int nb, input logic wpn);
		u_spi_master_model.start(md, wpn);
		u_spi_master_model.shift({24'h0, op}, 8, r);
		if (nb > 0)
			u_spi_master_model.shift({24'h0, pay}, nb, r);
		u_spi_master_model.stop();
	endtask

	// Array access; SI is held at the bits of d during reads and must be ignored
	task automatic mem(input logic [7:0] op, input logic [23:0] a, input logic [31:0] d, input int nb);
		u_spi_master_model.start(md, 1'b1);
		u_spi_master_model.shift({24'h0, op}, 8, r);
		u_spi_master_model.shift({8'h0, a}, 24, r);
		u_spi_master_model.shift(d, nb, r);
		u_spi_master_model.stop();
	endtask

	// Two status bytes back to back, then SO floats once deselected
	task automatic stat_chk(input logic [7:0] exp);
		u_spi_master_model.start(md, 1'b1);
		u_spi_master_model.shift(32'h05, 8, r);
		u_spi_master_model.shift(32'h5A5A, 16, r);
		check(r[15:8], exp);
		check(r[7:0], exp);
		u_spi_master_model.stop();
		check({7'h00, so_oe_n}, 8'h01);
	endtask

	// Watchdog well beyond the expected run of about 0.15 ms
	initial
	begin
		#400000;
		n_mismatch++;
		summarize();
	end

	initial
	begin
		repeat (10) @(posedge i_mclk);
		#1;
		i_rst = 1'b0;
		u_spi_master_model.tick(4);
		stat_chk(8'h00);
		$display("reset test done");
		// Alternate modes so both clock idle levels are used
		foreach (rows[i])
		begin
			md = i[0];
			if (rows[i].pre !== 8'h00)
				cmd(rows[i].pre, 8'h00, 0, 1'b1);
			cmd(rows[i].op, rows[i].arg, (rows[i].op == 8'h01) ? 8 : 0, rows[i].wp_n);
			stat_chk(rows[i].exp);
			$display("row %0d done", i);
		end
		// Burst across the top address with dropped upper address bits
		md = 1'b0;
		cmd(8'h06, 8'h00, 0, 1'b1);
		mem(8'h02, 24'hFFFFFE, 32'h00A55AC3, 24);
		md = 1'b1;
		mem(8'h03, 24'h03FFFE, 32'h00FFFFFF, 24);
		check(r[23:16], 8'hA5);
		check(r[15:8], 8'h5A);
		check(r[7:0], 8'hC3);
		stat_chk(8'h00);
		$display("wrap test done");
		// Write with the latch clear, then a byte cut short by deselect
		cmd(8'h06, 8'h00, 0, 1'b1);
		mem(8'h02, 24'h000010, 32'h1122, 16);
		mem(8'h02, 24'h000010, 32'h77, 8);
		cmd(8'h06, 8'h00, 0, 1'b1);
		mem(8'h02, 24'h000011, 32'hF, 4);
		mem(8'h03, 24'h000010, 32'h0, 16);
		check(r[15:8], 8'h11);
		check(r[7:0], 8'h22);
		$display("partial byte test done");
		// Upper quarter guarded: top byte kept, wrapped byte written
		md = 1'b0;
		cmd(8'h06, 8'h00, 0, 1'b1);
		cmd(8'h01, 8'h04, 8, 1'b1);
		cmd(8'h06, 8'h00, 0, 1'b1);
		mem(8'h02, 24'h03FFFF, 32'h9966, 16);
		mem(8'h03, 24'h03FFFF, 32'h0, 16);
		check(r[15:8], 8'h5A);
		check(r[7:0], 8'h66);
		cmd(8'h06, 8'h00, 0, 1'b1);
		cmd(8'h01, 8'h00, 8, 1'b1);
		$display("guard test done");
		// Seven op-code bits of latch-set must do nothing
		u_spi_master_model.start(md, 1'b1);
		u_spi_master_model.shift(32'h03, 7, r);
		u_spi_master_model.stop();
		stat_chk(8'h00);
		$display("short op-code test done");
		summarize();
	end
endmodule
